// >>> hdl/cba_pkg.sv
// Constants shared by the card block access logic
`default_nettype none
package cba_pkg;
    localparam int BLOCK_BYTES = 512;
    localparam int BLOCK_CNT_W = 10;
    localparam int ERASE_SMALL = 32;
    localparam int ERASE_LARGE = 64;
    localparam int NUM_BUFS = 2;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_WIDTH = 8;
    localparam int PROG_TIME_NS = 2000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] LAST_BYTE = 10'h1FF;
    localparam logic [6:0] PROG_CNT_MAX = 7'(PROG_CYCLES - 1);
    typedef enum logic [1:0] {
        CBA_IDLE = 2'b00,
        CBA_SINGLE = 2'b01,
        CBA_MULTI = 2'b10
    } cba_mode_t;
endpackage
`default_nettype wire

// >>> hdl/cba_fifo.sv
// Small valid/ready FIFO for write data
`default_nettype none
module cba_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem[rd_reg];
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) wr_reg <= AW'(wr_reg + 1'b1);
            if (pop) rd_reg <= AW'(rd_reg + 1'b1);
            cnt_reg <= (AW+1)'(cnt_reg + push - pop);
        end
    end
endmodule
`default_nettype wire

// >>> hdl/cba_card.sv
// Card-side write data path: block buffers, programming and DAT busy
// What this block does
// - Single mode one block, multi until stop
// - Multi write fills free buffers during programming
// - Multi write busy only when buffers full
// - Single write: DAT low until programmed
// - 512-byte blocks; rewrite touches erase unit
`default_nettype none
module cba_card (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic link_clk,
    input wire logic start_single,
    input wire logic start_multi,
    input wire logic stop_cmd,
    input wire logic large_card,
    input wire logic dat_in,
    output logic dat_out,
    output logic dat_oe_n,
    output logic busy,
    output logic [1:0] mode,
    output logic block_done,
    output logic [6:0] erase_blocks,
    output logic [7:0] prog_byte
);
    // ------------------------------------------------------------
    // Link sampling
    // ------------------------------------------------------------
    logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
    logic dat_s1_reg, dat_s2_reg;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            clk_s1_reg <= 1'b0;
            clk_s2_reg <= 1'b0;
            clk_s3_reg <= 1'b0;
            dat_s1_reg <= 1'b1;
            dat_s2_reg <= 1'b1;
        end else begin
            clk_s1_reg <= link_clk;
            clk_s2_reg <= clk_s1_reg;
            clk_s3_reg <= clk_s2_reg;
            dat_s1_reg <= dat_in;
            dat_s2_reg <= dat_s1_reg;
        end
    end
    wire clk_rise = clk_s2_reg && !clk_s3_reg;
    // ------------------------------------------------------------
    // Mode control
    // ------------------------------------------------------------
    cba_pkg::cba_mode_t mode_reg, mode_next;
    logic [cba_pkg::BLOCK_CNT_W-1:0] byte_reg;
    logic [cba_pkg::NUM_BUFS-1:0] full_reg;
    logic [6:0] prog_cnt_reg;
    logic prog_reg;
    logic [7:0] shift_reg;
    logic [2:0] bit_reg;
    logic busy_reg;
    logic done_reg;
    logic [7:0] prog_byte_reg;
    wire fifo_in_ready, fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire all_full = &full_reg;
    wire any_full = |full_reg;
    wire buf_free = !all_full;
    wire block_end = (byte_reg == cba_pkg::LAST_BYTE);
    wire bit_take = clk_rise && !busy_reg && (mode_reg != cba_pkg::CBA_IDLE)
        && buf_free && fifo_in_ready;
    wire byte_ready = bit_take && (bit_reg == 3'd7);
    // Bytes leave the FIFO whenever a block buffer can take them
    wire pop = fifo_out_valid && buf_free;
    wire prog_start = !prog_reg && any_full;
    wire prog_end = prog_reg && (prog_cnt_reg == cba_pkg::PROG_CNT_MAX);
    wire blk_fill = pop && block_end;
    wire [cba_pkg::NUM_BUFS-1:0] fill_onehot = full_reg[0] ?
        cba_pkg::NUM_BUFS'(2) : cba_pkg::NUM_BUFS'(1);
    wire [cba_pkg::NUM_BUFS-1:0] drain_onehot = full_reg[0] ?
        cba_pkg::NUM_BUFS'(1) : cba_pkg::NUM_BUFS'(2);
    wire busy_next = (mode_reg == cba_pkg::CBA_SINGLE) ? any_full
        : all_full;
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            cba_pkg::CBA_IDLE: begin
                if (start_multi) mode_next = cba_pkg::CBA_MULTI;
                else if (start_single) mode_next = cba_pkg::CBA_SINGLE;
            end
            cba_pkg::CBA_SINGLE: begin
                if (prog_end) mode_next = cba_pkg::CBA_IDLE;
            end
            cba_pkg::CBA_MULTI: begin
                if (stop_cmd) mode_next = cba_pkg::CBA_IDLE;
            end
            default: mode_next = cba_pkg::CBA_IDLE;
        endcase
    end
    // ------------------------------------------------------------
    // Bit collection into bytes and block buffers
    // ------------------------------------------------------------
    logic accept_reg;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mode_reg <= cba_pkg::CBA_IDLE;
            shift_reg <= 8'h00;
            bit_reg <= 3'd0;
            accept_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            accept_reg <= byte_ready;
            if (bit_take) begin
                shift_reg <= {shift_reg[6:0], dat_s2_reg};
                bit_reg <= 3'(bit_reg + 3'd1);
            end
        end
    end
    // Per-buffer full flags, both may be set; a buffer fills after 512 popped bytes
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            full_reg <= '0;
        end else begin
            // Fill next free buffer while the other programs; set wins over drain
            full_reg <= (full_reg & ~(prog_end ? drain_onehot : '0))
                | (blk_fill ? fill_onehot : '0);
        end
    end
    // ------------------------------------------------------------
    // Programming of a full buffer
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prog_reg <= 1'b0;
            prog_cnt_reg <= '0;
            byte_reg <= '0;
            done_reg <= 1'b0;
            prog_byte_reg <= 8'h00;
        end else begin
            done_reg <= prog_end;
            if (pop) begin
                prog_byte_reg <= fifo_out_data;
                byte_reg <= block_end ? '0 : 10'(byte_reg + 10'd1);
            end
            if (prog_start) begin
                prog_reg <= 1'b1;
                prog_cnt_reg <= '0;
            end else if (prog_end) begin
                prog_reg <= 1'b0;
            end else if (prog_reg) begin
                prog_cnt_reg <= 7'(prog_cnt_reg + 7'd1);
            end
        end
    end
    // ------------------------------------------------------------
    // Busy on DAT and status
    // ------------------------------------------------------------
    logic [6:0] erase_reg;
    logic dat_oe_n_reg;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            busy_reg <= 1'b0;
            dat_oe_n_reg <= 1'b1;
            erase_reg <= 7'd32;
        end else begin
            busy_reg <= busy_next && (mode_reg != cba_pkg::CBA_IDLE);
            dat_oe_n_reg <= !(busy_next && (mode_reg != cba_pkg::CBA_IDLE));
            erase_reg <= large_card ? 7'(cba_pkg::ERASE_LARGE)
                : 7'(cba_pkg::ERASE_SMALL);
        end
    end
    assign dat_out = 1'b0;
    assign dat_oe_n = dat_oe_n_reg;
    assign busy = busy_reg;
    assign mode = mode_reg;
    assign block_done = done_reg;
    assign erase_blocks = erase_reg;
    assign prog_byte = prog_byte_reg;
    cba_fifo #(.WIDTH(cba_pkg::FIFO_WIDTH), .DEPTH(cba_pkg::FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .resetn(resetn),
        .in_valid(accept_reg),
        .in_ready(fifo_in_ready),
        .in_data(shift_reg),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );
endmodule
`default_nettype wire

// >>> verification/cba_card_properties.sv
// Port checker of the card write path
`default_nettype none
module cba_card_properties (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic start_single,
    input wire logic start_multi,
    input wire logic stop_cmd,
    input wire logic large_card,
    input wire logic dat_out,
    input wire logic dat_oe_n,
    input wire logic busy,
    input wire logic [1:0] mode,
    input wire logic block_done,
    input wire logic [6:0] erase_blocks
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    single_start_a: assert property (start_single && mode == 2'd0 |=> mode == 2'd1)
        else $error("single start lost");
    multi_start_a: assert property (start_multi && mode == 2'd0 |=> mode == 2'd2)
        else $error("multi start lost");
    multi_stop_a: assert property (stop_cmd && mode == 2'd2 |-> ##[1:100] mode == 2'd0)
        else $error("stop not taken");
    single_end_a: assert property (block_done && $past(mode) == 2'd1 |-> mode == 2'd0)
        else $error("single mode stays");
    busy_pin_a: assert property (busy |-> ##[0:2] !dat_oe_n)
        else $error("busy not on pin");
    drive_low_a: assert property (!dat_oe_n |-> !dat_out)
        else $error("pin driven high");
    busy_bound_a: assert property ($rose(busy) |-> ##[1:60] !busy)
        else $error("busy too long");
    erase_size_a: assert property ($stable(large_card) |->
        erase_blocks == (large_card ? 7'd64 : 7'd32))
        else $error("erase size wrong");
endmodule
bind cba_card cba_card_properties chk_u (.*);
`default_nettype wire

// >>> verification/cba_host.sv
// Host model: clocks the link and shifts blocks onto the data line
`default_nettype none
module cba_host (
    input wire logic mclk,
    input wire logic dat_in,
    output logic link_clk,
    output logic host_bit,
    output logic host_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        link_clk = 1'b0;
        host_bit = 1'b1;
        host_oe_n = 1'b1;
    end
    // Bytes are seed xor index, MSB first; link clock runs only in frame
    task automatic send_block(input logic [7:0] seed);
        logic [7:0] b;
        while (dat_in !== 1'b1) @(posedge mclk);
        for (int i = 0; i < cba_pkg::BLOCK_BYTES; i++) begin
            b = 8'(i) ^ seed;
            for (int k = 7; k >= 0; k--) begin
                host_oe_n <= 1'b0;
                host_bit <= b[k];
                repeat (4) @(posedge mclk);
                link_clk <= 1'b1;
                repeat (4) @(posedge mclk);
                link_clk <= 1'b0;
            end
        end
        host_oe_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// >>> verification/cba_card_bench.sv
// Self-checking bench of the card write path
`default_nettype none
module cba_card_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, resetn, start_single, start_multi, stop_cmd, large_card;
    logic link_clk, host_bit, host_oe_n, dat_out, dat_oe_n, busy, block_done;
    logic [1:0] mode;
    logic [6:0] erase_blocks;
    logic [7:0] prog_byte;
    wire logic dat_in;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    // Open line with pull-up: low if either side pulls it low
    assign dat_in = (dat_oe_n | dat_out) & (host_oe_n | host_bit);
    cba_host host_u (.*);
    cba_card dut_u (.*);
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wait_done(output int nb);
        nb = 0;
        for (int i = 0; i < 200; i++) begin
            @(negedge mclk);
            nb += int'(busy === 1'b1);
            if (block_done === 1'b1) break;
        end
    endtask
    task automatic single_write();
        int nb;
        large_card <= 1'b1;
        start_single <= 1'b1;
        @(posedge mclk);
        start_single <= 1'b0;
        host_u.send_block(8'h5A);
        wait_done(nb);
        chk("single busy", 8'h01, 8'(nb > 30));
        chk("last byte", 8'hA5, prog_byte);
        chk("erase size", 8'h40, 8'(erase_blocks));
        for (int i = 0; i < 100 && mode !== 2'd0; i++) @(negedge mclk);
        chk("single end", 8'h00, 8'(mode));
        @(negedge mclk);
        chk("dat release", 8'h01, 8'(dat_oe_n));
    endtask
    task automatic multi_write();
        int nb;
        large_card <= 1'b0;
        start_multi <= 1'b1;
        @(posedge mclk);
        start_multi <= 1'b0;
        host_u.send_block(8'h3C);
        wait_done(nb);
        chk("multi busy", 8'h00, 8'(nb));
        chk("last byte", 8'hC3, prog_byte);
        chk("erase size", 8'h20, 8'(erase_blocks));
        chk("multi mode", 8'h02, 8'(mode));
        @(posedge mclk);
        stop_cmd <= 1'b1;
        @(posedge mclk);
        stop_cmd <= 1'b0;
        for (int i = 0; i < 100 && mode !== 2'd0; i++) @(negedge mclk);
        chk("stop mode", 8'h00, 8'(mode));
    endtask
    initial begin
        resetn = 1'b0;
        start_single = 1'b0;
        start_multi = 1'b0;
        stop_cmd = 1'b0;
        large_card = 1'b0;
        repeat (16) @(posedge mclk);
        chk("reset oe", 8'h01, 8'(dat_oe_n));
        resetn <= 1'b1;
        @(posedge mclk);
        single_write();
        multi_write();
        final_report();
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 80000) begin
            bad_count++;
            final_report();
        end
    end
endmodule
`default_nettype wire
